//--- dwc_defines.svh
// Register offsets, reset values, limits and codes of the warning compare block
`ifndef DWC_DEFINES_SVH
`define DWC_DEFINES_SVH

`define DWC_ADDR_MODE       8'h00
`define DWC_ADDR_PID_DEV    8'h04
`define DWC_ADDR_FB_UPPER   8'h08
`define DWC_ADDR_FB_LOWER   8'h0c
`define DWC_ADDR_TQ_FWD_PWR 8'h10
`define DWC_ADDR_TQ_REV_RGN 8'h14
`define DWC_ADDR_TQ_REV_PWR 8'h18
`define DWC_ADDR_TQ_FWD_RGN 8'h1c
`define DWC_ADDR_ZERO_SPD   8'h20
`define DWC_ADDR_HS_LEVEL   8'h24
`define DWC_ADDR_OL_LEVEL   8'h28
`define DWC_ADDR_OL_LEVEL_M2 8'h2c
`define DWC_ADDR_OL_LEVEL2  8'h30
`define DWC_ADDR_ARR_ACC    8'h34
`define DWC_ADDR_ARR_DEC    8'h38
`define DWC_ADDR_ARR_ACC2   8'h3c
`define DWC_ADDR_ARR_DEC2   8'h40
`define DWC_ADDR_THERM      8'h44
`define DWC_ADDR_PSCALE     8'h48
`define DWC_ADDR_ROUTE      8'h4c
`define DWC_ADDR_STATUS     8'h50

`define DWC_MODE_TQ_DIR_BIT  0
`define DWC_MODE_TQ_MODE_BIT 1
`define DWC_MODE_OL_MODE_BIT 2

`define DWC_RST_MODE      3'h6
`define DWC_RST_PID_DEV   10'h01e
`define DWC_RST_FB_UPPER  10'h3e8
`define DWC_RST_FB_LOWER  10'h000
`define DWC_RST_TORQUE    8'h64
`define DWC_RST_ZERO_SPD  16'h0000
`define DWC_RST_HS_LEVEL  7'h64
`define DWC_RST_OL_LEVEL  9'h064
`define DWC_RST_ARRIVAL   16'h0000
`define DWC_RST_THERM     7'h5a
`define DWC_RST_PSCALE    14'h0064
`define DWC_RST_ROUTE     12'hfff

`define DWC_MAX_PCT       10'h3e8
`define DWC_MAX_TORQUE    8'hc8
`define DWC_MAX_ZERO_SPD  16'h2710
`define DWC_MAX_HS        7'h6e
`define DWC_MAX_OL        9'h140
`define DWC_MAX_ARRIVAL   16'h9c40
`define DWC_MAX_THERM     7'h64
`define DWC_MIN_PSCALE    14'h0001
`define DWC_MAX_PSCALE    14'h270f
`define DWC_PSCALE_UNIT   17'h00064

`endif

//--- dwc_pkg.sv
// Types shared by the warning compare block
package dwc_pkg;

  typedef enum logic [1:0] {
    DWC_CURVE_CT,
    DWC_CURVE_VP,
    DWC_CURVE_FREE,
    DWC_CURVE_SLV
  } dwc_curve_e;

  typedef enum logic [1:0] {
    DWC_PH_STOP,
    DWC_PH_ACCEL,
    DWC_PH_DECEL,
    DWC_PH_CONST
  } dwc_phase_e;

  typedef struct packed {
    logic [9:0] setpoint_value;
    logic [9:0] process_variable;
    logic [15:0] out_freq;
    logic [7:0] torque_est;
    logic torque_rev;
    logic torque_regen;
    logic [8:0] out_current;
    logic [6:0] heatsink_temp;
    logic [6:0] thermal_load;
    dwc_phase_e phase;
    dwc_curve_e curve;
    logic motor2_sel;
  } dwc_meas_s;

  typedef struct packed {
    logic thermal_warn_flag;
    logic pid_stage2_flag;
    logic freq_arrival_flag_b;
    logic freq_arrival_flag_a;
    logic overload_warn_flag2;
    logic overload_warn_flag;
    logic heatsink_hot_flag;
    logic zero_speed_flag;
    logic torque_limit_flag;
    logic pid_deviation_flag;
  } dwc_flags_s;

endpackage : dwc_pkg

//--- dwc_compare.sv
// Warning threshold comparison and output terminal routing of the drive
//
// Summary of operation
// - PID deviation flag when error exceeds level
// - Torque direction select: over or under
// - Torque flag only valid under sensorless vector
// - Four quadrant torque thresholds, default 100%
// - Torque mode gates: accel, decel and constant (not standstill) or constant only
// - Zero-speed flag while frequency below level
// - Zero-speed routable to terminals or relay
// - Zero-speed works under all four curves
// - Heat-sink flag when temperature exceeds level
// - Overload mode gates: accel, decel and constant (not standstill) or constant only
// - Overload levels 0.01-3.20 rated, 0 disables
// - Second overload level, default rated current
// - Arrival thresholds for acceleration and deceleration
// - Second pair of arrival thresholds
// - PV above upper limit turns stage two off
// - PV below lower limit turns stage two on
// - Thermal warning level, zero disables it
// - Pulse output scaled by 0.01-99.99 factor
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ns
`include "dwc_defines.svh"

module dwc_compare
  import dwc_pkg::*;
#(
  parameter int FLAG_COUNT = 10
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire dwc_meas_s meas_i,
  input wire logic pulse_in_i,
  output logic pulse_out_o,
  output dwc_flags_s flags_o,
  output logic term1_o,
  output logic term2_o,
  output logic relay_o
);

  logic [2:0] mode_q;
  logic [9:0] pid_dev_level_q;
  logic [9:0] pid_fb_upper_q;
  logic [9:0] pid_fb_lower_q;
  logic [7:0] torque_lvl_q [4];
  logic [15:0] zero_speed_level_q;
  logic [6:0] heatsink_warn_level_q;
  logic [8:0] ol_level_q;
  logic [8:0] ol_level_m2_q;
  logic [8:0] ol_level2_q;
  logic [15:0] arrival_accel_thr_q;
  logic [15:0] arrival_decel_thr_q;
  logic [15:0] arrival_accel_thr2_q;
  logic [15:0] arrival_decel_thr2_q;
  logic [6:0] thermal_warn_level_q;
  logic [13:0] pulse_scale_q;
  logic [11:0] route_q;
  dwc_flags_s flags_q;
  dwc_flags_s flags_d;
  logic [FLAG_COUNT-1:0] flag_vec;
  logic [31:0] rdata_d;
  logic [16:0] pulse_acc_q;
  logic [16:0] pulse_acc_d;
  logic pulse_out_q;

  logic torque_dir_sel;
  logic torque_mode_sel;
  logic overload_mode_sel;
  logic [9:0] pid_err;
  logic [7:0] torque_level;
  logic [8:0] ol_level_sel;
  logic at_const;
  logic at_run;
  logic torque_hit;

  // Out-of-range writes saturate at the top of the legal span
  function automatic logic [15:0] sat(input logic [31:0] v, input logic [15:0] mx);
    sat = (v > {16'h0000, mx}) ? mx : v[15:0];
  endfunction : sat

  assign torque_dir_sel = mode_q[`DWC_MODE_TQ_DIR_BIT];
  assign torque_mode_sel = mode_q[`DWC_MODE_TQ_MODE_BIT];
  assign overload_mode_sel = mode_q[`DWC_MODE_OL_MODE_BIT];

  // Register writes
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_q <= `DWC_RST_MODE;
      pid_dev_level_q <= `DWC_RST_PID_DEV;
      pid_fb_upper_q <= `DWC_RST_FB_UPPER;
      pid_fb_lower_q <= `DWC_RST_FB_LOWER;
      torque_lvl_q <= '{default: `DWC_RST_TORQUE};
      zero_speed_level_q <= `DWC_RST_ZERO_SPD;
      heatsink_warn_level_q <= `DWC_RST_HS_LEVEL;
      ol_level_q <= `DWC_RST_OL_LEVEL;
      ol_level_m2_q <= `DWC_RST_OL_LEVEL;
      ol_level2_q <= `DWC_RST_OL_LEVEL;
      arrival_accel_thr_q <= `DWC_RST_ARRIVAL;
      arrival_decel_thr_q <= `DWC_RST_ARRIVAL;
      arrival_accel_thr2_q <= `DWC_RST_ARRIVAL;
      arrival_decel_thr2_q <= `DWC_RST_ARRIVAL;
      thermal_warn_level_q <= `DWC_RST_THERM;
      pulse_scale_q <= `DWC_RST_PSCALE;
      route_q <= `DWC_RST_ROUTE;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `DWC_ADDR_MODE)
        mode_q <= reg_wdata_i[2:0];
      else if (reg_addr_i == `DWC_ADDR_PID_DEV)
        pid_dev_level_q <= 10'(sat(reg_wdata_i, 16'(`DWC_MAX_PCT)));
      else if (reg_addr_i == `DWC_ADDR_FB_UPPER)
        pid_fb_upper_q <= 10'(sat(reg_wdata_i, 16'(`DWC_MAX_PCT)));
      else if (reg_addr_i == `DWC_ADDR_FB_LOWER)
        pid_fb_lower_q <= 10'(sat(reg_wdata_i, 16'(`DWC_MAX_PCT)));
      else if (reg_addr_i == `DWC_ADDR_TQ_FWD_PWR)
        torque_lvl_q[0] <= 8'(sat(reg_wdata_i, 16'(`DWC_MAX_TORQUE)));
      else if (reg_addr_i == `DWC_ADDR_TQ_REV_RGN)
        torque_lvl_q[1] <= 8'(sat(reg_wdata_i, 16'(`DWC_MAX_TORQUE)));
      else if (reg_addr_i == `DWC_ADDR_TQ_REV_PWR)
        torque_lvl_q[2] <= 8'(sat(reg_wdata_i, 16'(`DWC_MAX_TORQUE)));
      else if (reg_addr_i == `DWC_ADDR_TQ_FWD_RGN)
        torque_lvl_q[3] <= 8'(sat(reg_wdata_i, 16'(`DWC_MAX_TORQUE)));
      else if (reg_addr_i == `DWC_ADDR_ZERO_SPD)
        zero_speed_level_q <= sat(reg_wdata_i, `DWC_MAX_ZERO_SPD);
      else if (reg_addr_i == `DWC_ADDR_HS_LEVEL)
        heatsink_warn_level_q <= 7'(sat(reg_wdata_i, 16'(`DWC_MAX_HS)));
      else if (reg_addr_i == `DWC_ADDR_OL_LEVEL)
        ol_level_q <= 9'(sat(reg_wdata_i, 16'(`DWC_MAX_OL)));
      else if (reg_addr_i == `DWC_ADDR_OL_LEVEL_M2)
        ol_level_m2_q <= 9'(sat(reg_wdata_i, 16'(`DWC_MAX_OL)));
      else if (reg_addr_i == `DWC_ADDR_OL_LEVEL2)
        ol_level2_q <= 9'(sat(reg_wdata_i, 16'(`DWC_MAX_OL)));
      else if (reg_addr_i == `DWC_ADDR_ARR_ACC)
        arrival_accel_thr_q <= sat(reg_wdata_i, `DWC_MAX_ARRIVAL);
      else if (reg_addr_i == `DWC_ADDR_ARR_DEC)
        arrival_decel_thr_q <= sat(reg_wdata_i, `DWC_MAX_ARRIVAL);
      else if (reg_addr_i == `DWC_ADDR_ARR_ACC2)
        arrival_accel_thr2_q <= sat(reg_wdata_i, `DWC_MAX_ARRIVAL);
      else if (reg_addr_i == `DWC_ADDR_ARR_DEC2)
        arrival_decel_thr2_q <= sat(reg_wdata_i, `DWC_MAX_ARRIVAL);
      else if (reg_addr_i == `DWC_ADDR_THERM)
        thermal_warn_level_q <= 7'(sat(reg_wdata_i, 16'(`DWC_MAX_THERM)));
      else if (reg_addr_i == `DWC_ADDR_PSCALE)
      begin
        // A zero factor would silence the output, so it is lifted to the minimum
        if (reg_wdata_i == 32'h0000_0000)
          pulse_scale_q <= `DWC_MIN_PSCALE;
        else
          pulse_scale_q <= 14'(sat(reg_wdata_i, 16'(`DWC_MAX_PSCALE)));
      end
      else if (reg_addr_i == `DWC_ADDR_ROUTE)
        route_q <= reg_wdata_i[11:0];
    end
  end

  // Read mux, answered one cycle after the strobe
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (reg_addr_i == `DWC_ADDR_MODE)
      rdata_d = {29'h0, mode_q};
    else if (reg_addr_i == `DWC_ADDR_PID_DEV)
      rdata_d = {22'h0, pid_dev_level_q};
    else if (reg_addr_i == `DWC_ADDR_FB_UPPER)
      rdata_d = {22'h0, pid_fb_upper_q};
    else if (reg_addr_i == `DWC_ADDR_FB_LOWER)
      rdata_d = {22'h0, pid_fb_lower_q};
    else if (reg_addr_i == `DWC_ADDR_TQ_FWD_PWR)
      rdata_d = {24'h0, torque_lvl_q[0]};
    else if (reg_addr_i == `DWC_ADDR_TQ_REV_RGN)
      rdata_d = {24'h0, torque_lvl_q[1]};
    else if (reg_addr_i == `DWC_ADDR_TQ_REV_PWR)
      rdata_d = {24'h0, torque_lvl_q[2]};
    else if (reg_addr_i == `DWC_ADDR_TQ_FWD_RGN)
      rdata_d = {24'h0, torque_lvl_q[3]};
    else if (reg_addr_i == `DWC_ADDR_ZERO_SPD)
      rdata_d = {16'h0, zero_speed_level_q};
    else if (reg_addr_i == `DWC_ADDR_HS_LEVEL)
      rdata_d = {25'h0, heatsink_warn_level_q};
    else if (reg_addr_i == `DWC_ADDR_OL_LEVEL)
      rdata_d = {23'h0, ol_level_q};
    else if (reg_addr_i == `DWC_ADDR_OL_LEVEL_M2)
      rdata_d = {23'h0, ol_level_m2_q};
    else if (reg_addr_i == `DWC_ADDR_OL_LEVEL2)
      rdata_d = {23'h0, ol_level2_q};
    else if (reg_addr_i == `DWC_ADDR_ARR_ACC)
      rdata_d = {16'h0, arrival_accel_thr_q};
    else if (reg_addr_i == `DWC_ADDR_ARR_DEC)
      rdata_d = {16'h0, arrival_decel_thr_q};
    else if (reg_addr_i == `DWC_ADDR_ARR_ACC2)
      rdata_d = {16'h0, arrival_accel_thr2_q};
    else if (reg_addr_i == `DWC_ADDR_ARR_DEC2)
      rdata_d = {16'h0, arrival_decel_thr2_q};
    else if (reg_addr_i == `DWC_ADDR_THERM)
      rdata_d = {25'h0, thermal_warn_level_q};
    else if (reg_addr_i == `DWC_ADDR_PSCALE)
      rdata_d = {18'h0, pulse_scale_q};
    else if (reg_addr_i == `DWC_ADDR_ROUTE)
      rdata_d = {20'h0, route_q};
    else if (reg_addr_i == `DWC_ADDR_STATUS)
      rdata_d = {22'h0, flags_q};
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (reg_rd_i)
      reg_rdata_o <= rdata_d;
    else
      reg_rdata_o <= 32'h0000_0000;
  end

  // Shared comparison terms
  assign at_const = (meas_i.phase == DWC_PH_CONST);
  // Mode 00 covers accel, decel and constant speed only; standstill never raises the torque or overload flags
  assign at_run = (meas_i.phase != DWC_PH_STOP);
  assign pid_err = (meas_i.setpoint_value >= meas_i.process_variable) ?
                   (meas_i.setpoint_value - meas_i.process_variable) :
                   (meas_i.process_variable - meas_i.setpoint_value);

  // Quadrant picks the threshold: forward/reverse crossed with power/regeneration
  always_comb
  begin
    torque_level = torque_lvl_q[0];
    if (!meas_i.torque_rev && !meas_i.torque_regen)
      torque_level = torque_lvl_q[0];
    else if (meas_i.torque_rev && meas_i.torque_regen)
      torque_level = torque_lvl_q[1];
    else if (meas_i.torque_rev)
      torque_level = torque_lvl_q[2];
    else
      torque_level = torque_lvl_q[3];
  end

  // Over-torque above the level, under-torque below it
  assign torque_hit = torque_dir_sel ? (meas_i.torque_est < torque_level) :
                                       (meas_i.torque_est > torque_level);

  assign ol_level_sel = meas_i.motor2_sel ? ol_level_m2_q : ol_level_q;

  // Next flag values, one evaluation per clock
  always_comb
  begin
    flags_d = flags_q;
    flags_d.pid_deviation_flag = (pid_err > pid_dev_level_q);
    // Torque estimate is meaningless off sensorless vector, so the flag is held low
    flags_d.torque_limit_flag = (meas_i.curve == DWC_CURVE_SLV) && torque_hit &&
                                (torque_mode_sel ? at_const : at_run);
    // Every curve runs on output frequency, so no curve gating here
    flags_d.zero_speed_flag = (meas_i.out_freq < zero_speed_level_q);
    flags_d.heatsink_hot_flag = (meas_i.heatsink_temp > heatsink_warn_level_q);
    flags_d.overload_warn_flag = (ol_level_sel != 9'h000) &&
                                 (meas_i.out_current > ol_level_sel) &&
                                 (overload_mode_sel ? at_const : at_run);
    flags_d.overload_warn_flag2 = (ol_level2_q != 9'h000) &&
                                  (meas_i.out_current > ol_level2_q) &&
                                  (overload_mode_sel ? at_const : at_run);
    flags_d.thermal_warn_flag = (thermal_warn_level_q != 7'h00) &&
                                (meas_i.thermal_load > thermal_warn_level_q);
    // Arrival: set on reaching the accel threshold, cleared under the decel one
    if (meas_i.phase == DWC_PH_STOP)
      flags_d.freq_arrival_flag_a = 1'b0;
    else if (meas_i.phase == DWC_PH_ACCEL && meas_i.out_freq >= arrival_accel_thr_q)
      flags_d.freq_arrival_flag_a = 1'b1;
    else if (meas_i.phase == DWC_PH_DECEL && meas_i.out_freq < arrival_decel_thr_q)
      flags_d.freq_arrival_flag_a = 1'b0;
    if (meas_i.phase == DWC_PH_STOP)
      flags_d.freq_arrival_flag_b = 1'b0;
    else if (meas_i.phase == DWC_PH_ACCEL && meas_i.out_freq >= arrival_accel_thr2_q)
      flags_d.freq_arrival_flag_b = 1'b1;
    else if (meas_i.phase == DWC_PH_DECEL && meas_i.out_freq < arrival_decel_thr2_q)
      flags_d.freq_arrival_flag_b = 1'b0;
    // Between the limits the second stage keeps its state
    if (meas_i.process_variable > pid_fb_upper_q)
      flags_d.pid_stage2_flag = 1'b0;
    else if (meas_i.process_variable < pid_fb_lower_q)
      flags_d.pid_stage2_flag = 1'b1;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      flags_q <= '0;
    else
      flags_q <= flags_d;
  end

  assign flags_o = flags_q;
  assign flag_vec = flags_q;

  // Terminal routing; codes beyond the flag count leave the terminal off
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      term1_o <= 1'b0;
      term2_o <= 1'b0;
      relay_o <= 1'b0;
    end
    else
    begin
      term1_o <= (route_q[3:0] < 4'(FLAG_COUNT)) && flag_vec[route_q[3:0]];
      term2_o <= (route_q[7:4] < 4'(FLAG_COUNT)) && flag_vec[route_q[7:4]];
      relay_o <= (route_q[11:8] < 4'(FLAG_COUNT)) && flag_vec[route_q[11:8]];
    end
  end

  // Pulse scaling: each input pulse adds the factor, each output pulse spends one unit.
  // At most one output pulse per clock, so large factors on dense input saturate.
  always_comb
  begin
    pulse_acc_d = pulse_acc_q;
    if (pulse_acc_q >= `DWC_PSCALE_UNIT)
      pulse_acc_d = pulse_acc_d - `DWC_PSCALE_UNIT;
    if (pulse_in_i && pulse_acc_d <= 17'h1ffff - 17'(pulse_scale_q))
      pulse_acc_d = pulse_acc_d + 17'(pulse_scale_q);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pulse_acc_q <= 17'h00000;
      pulse_out_q <= 1'b0;
    end
    else
    begin
      pulse_acc_q <= pulse_acc_d;
      pulse_out_q <= (pulse_acc_q >= `DWC_PSCALE_UNIT);
    end
  end

  assign pulse_out_o = pulse_out_q;

endmodule : dwc_compare

//--- dwc_assertions.sv
// Port checker for the warning compare block
`timescale 1ns/1ns
module dwc_checker
  import dwc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire dwc_meas_s meas_i,
  input wire logic pulse_in_i,
  input wire logic pulse_out_o,
  input wire dwc_flags_s flags_o,
  input wire logic term1_o,
  input wire logic term2_o,
  input wire logic relay_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read cycle");
  torque_curve_a: assert property ($past(meas_i.curve) != DWC_CURVE_SLV
    |-> !flags_o.torque_limit_flag) else $error("torque flag without vector control");
  therm_off_a: assert property (flags_o.thermal_warn_flag
    |-> $past(meas_i.thermal_load) != 7'h0) else $error("thermal flag at zero load");
  ol_off_a: assert property (flags_o.overload_warn_flag
    |-> $past(meas_i.out_current) != 9'h0) else $error("overload flag at zero current");
  hs_over_a: assert property ($past(meas_i.heatsink_temp) > 7'h6e
    |-> flags_o.heatsink_hot_flag) else $error("heat sink flag missing");
  zero_bound_a: assert property (flags_o.zero_speed_flag
    |-> $past(meas_i.out_freq) < 16'h2710) else $error("zero speed above top level");
  pid_equal_a: assert property ($past(meas_i.setpoint_value) ==
    $past(meas_i.process_variable) |-> !flags_o.pid_deviation_flag)
    else $error("deviation flag with no error");
  stage2_upper_a: assert property ($past(meas_i.process_variable) > 10'h3e8
    |-> !flags_o.pid_stage2_flag) else $error("stage two on above upper limit");
  arrival_stop_a: assert property ($past(meas_i.phase) == DWC_PH_STOP
    |-> !flags_o.freq_arrival_flag_a && !flags_o.freq_arrival_flag_b)
    else $error("arrival flag while stopped");
  term_src_a: assert property (term1_o || term2_o || relay_o
    |-> $past(flags_o) != 10'h0) else $error("terminal high with no flag");
  stop_gate_a: assert property ($past(meas_i.phase) == DWC_PH_STOP
    |-> !flags_o.torque_limit_flag && !flags_o.overload_warn_flag)
    else $error("torque or overload flag while stopped");

  zero_c: cover property (flags_o.zero_speed_flag);
  arrival_c: cover property ($rose(flags_o.freq_arrival_flag_a));
  pulse_c: cover property (pulse_out_o);
  torque_c: cover property (flags_o.torque_limit_flag);
endmodule : dwc_checker

//--- dwc_ctrl_model.sv
// Controller model at the output terminals: lift brake and pulse counter
`timescale 1ns/1ns
module dwc_ctrl_model
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic term1_i,
  input wire logic term2_i,
  input wire logic pulse_i,
  output logic brake_open_o,
  output logic [15:0] pulse_count_o
);
  // Term1 carries torque, term2 arrival; engaging wins so a clash stays safe
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      brake_open_o <= 1'b0;
    else if (term2_i)
      brake_open_o <= 1'b0;
    else if (term1_i)
      brake_open_o <= 1'b1;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pulse_count_o <= 16'h0;
    else if (pulse_i)
      pulse_count_o <= pulse_count_o + 16'h1;
  end
endmodule : dwc_ctrl_model

//--- tb.sv
// Self-checking bench of the warning compare block
`timescale 1ns/1ns
`include "dwc_defines.svh"
module tb;
  import dwc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  dwc_meas_s meas_i = '0;
  logic pulse_in_i = 1'b0;
  logic pulse_out_o;
  dwc_flags_s flags_o;
  logic term1_o;
  logic term2_o;
  logic relay_o;
  logic brake_open;
  logic [15:0] pulse_count;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic arr_a = 1'b0;
  logic arr_b = 1'b0;
  logic st2 = 1'b0;
  logic [31:0] rd;
  logic [95:0] raw;
  dwc_meas_s m;
  dwc_flags_s ef;
  logic [15:0] cfg [0:19] = '{`DWC_RST_MODE, `DWC_RST_PID_DEV, `DWC_RST_FB_UPPER,
    `DWC_RST_FB_LOWER, `DWC_RST_TORQUE, `DWC_RST_TORQUE, `DWC_RST_TORQUE, `DWC_RST_TORQUE,
    `DWC_RST_ZERO_SPD, `DWC_RST_HS_LEVEL, `DWC_RST_OL_LEVEL, `DWC_RST_OL_LEVEL,
    `DWC_RST_OL_LEVEL, `DWC_RST_ARRIVAL, `DWC_RST_ARRIVAL, `DWC_RST_ARRIVAL,
    `DWC_RST_ARRIVAL, `DWC_RST_THERM, `DWC_RST_PSCALE, `DWC_RST_ROUTE};
  logic [15:0] maxv [0:17] = '{16'h7, `DWC_MAX_PCT, `DWC_MAX_PCT, `DWC_MAX_PCT,
    `DWC_MAX_TORQUE, `DWC_MAX_TORQUE, `DWC_MAX_TORQUE, `DWC_MAX_TORQUE, `DWC_MAX_ZERO_SPD,
    `DWC_MAX_HS, `DWC_MAX_OL, `DWC_MAX_OL, `DWC_MAX_OL, `DWC_MAX_ARRIVAL, `DWC_MAX_ARRIVAL,
    `DWC_MAX_ARRIVAL, `DWC_MAX_ARRIVAL, `DWC_MAX_THERM};

  dwc_compare dut (.ref_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .meas_i, .pulse_in_i, .pulse_out_o, .flags_o, .term1_o, .term2_o, .relay_o);
  dwc_ctrl_model model (.ref_clk_i, .rst_i, .term1_i(term1_o), .term2_i(term2_o),
    .pulse_i(pulse_out_o), .brake_open_o(brake_open), .pulse_count_o(pulse_count));

  initial
  begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic complete_run();
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask : reg_read

  task automatic cfg_write(input int i, input logic [15:0] v);
    cfg[i] = v;
    reg_write(8'(i * 4), {16'h0, v});
  endtask : cfg_write

  // Mode 00 covers accel, decel and constant speed but not standstill
  function automatic logic gate(input logic sel, input dwc_phase_e p);
    return sel ? (p == DWC_PH_CONST) : (p != DWC_PH_STOP);
  endfunction : gate

  // Also steps the latched arrival and stage-two state, so call once per evaluation
  function automatic dwc_flags_s expect_flags(input dwc_meas_s x);
    dwc_flags_s f;
    logic [9:0] err;
    logic [15:0] ol;
    int q;
    err = (x.setpoint_value > x.process_variable) ? x.setpoint_value - x.process_variable
      : x.process_variable - x.setpoint_value;
    q = x.torque_rev ? (x.torque_regen ? 5 : 6) : (x.torque_regen ? 7 : 4);
    ol = x.motor2_sel ? cfg[11] : cfg[10];
    f.pid_deviation_flag = err > cfg[1];
    f.torque_limit_flag = x.curve == DWC_CURVE_SLV && gate(cfg[0][1], x.phase) &&
      (cfg[0][0] ? x.torque_est < cfg[q] : x.torque_est > cfg[q]);
    f.zero_speed_flag = x.out_freq < cfg[8];
    f.heatsink_hot_flag = x.heatsink_temp > cfg[9];
    f.overload_warn_flag = ol != 0 && gate(cfg[0][2], x.phase) && x.out_current > ol;
    f.overload_warn_flag2 = cfg[12] != 0 && gate(cfg[0][2], x.phase) && x.out_current > cfg[12];
    arr_a = x.phase != DWC_PH_STOP && (x.phase == DWC_PH_ACCEL && x.out_freq >= cfg[13] ||
      arr_a && !(x.phase == DWC_PH_DECEL && x.out_freq < cfg[14]));
    arr_b = x.phase != DWC_PH_STOP && (x.phase == DWC_PH_ACCEL && x.out_freq >= cfg[15] ||
      arr_b && !(x.phase == DWC_PH_DECEL && x.out_freq < cfg[16]));
    st2 = (x.process_variable > cfg[2]) ? 1'b0 : ((x.process_variable < cfg[3]) ? 1'b1 : st2);
    f.freq_arrival_flag_a = arr_a;
    f.freq_arrival_flag_b = arr_b;
    f.pid_stage2_flag = st2;
    f.thermal_warn_flag = cfg[17] != 0 && x.thermal_load > cfg[17];
    return f;
  endfunction : expect_flags

  initial
  begin
    void'($urandom(85572));
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 20; i++)
    begin
      reg_read(8'(i * 4), rd);
      check(rd, {16'h0, cfg[i]}, "reset value");
    end
    reg_read(8'h54, rd);
    check(rd, 32'h0, "unmapped read");
    reg_write(8'h10, 32'hffff);
    reg_read(8'h10, rd);
    check(rd, 32'd200, "torque level clamp");
    cfg[4] = 16'd200;
    reg_write(8'h48, 32'h0);
    reg_read(8'h48, rd);
    check(rd, 32'd1, "scale floor");
    cfg[18] = 16'd1;
    cfg_write(8, 16'd500);
    cfg_write(19, 16'h222);
    for (int c = 0; c < 8; c++)
    begin
      @(posedge ref_clk_i);
      meas_i.curve <= dwc_curve_e'(c % 4);
      meas_i.out_freq <= (c < 4) ? 16'd499 : 16'd500;
      repeat (3) @(posedge ref_clk_i);
      #1;
      check(32'({term1_o, term2_o, relay_o, flags_o.zero_speed_flag}), (c < 4) ? 32'hf : 32'h0,
        "zero speed routing");
    end
    for (int r = 0; r < 4; r++)
    begin
      // Park where stage two is off and arrival clear while levels change
      m = '0;
      m.process_variable = 10'h3ff;
      @(posedge ref_clk_i);
      meas_i <= m;
      void'(expect_flags(m));
      if (r > 0)
        for (int i = 0; i < 18; i++)
          cfg_write(i, (r == 3 && i inside {10, 11, 12, 17}) ? 16'h0
            : 16'($urandom_range(maxv[i])));
      cfg_write(19, 16'hf61);
      // Terminals lag the flags by one cycle, so each step checks the previous expectation
      ef = expect_flags(m);
      for (int n = 0; n < 250; n++)
      begin
        raw = {$urandom, $urandom, $urandom};
        m = raw[73:0];
        m.out_freq = 16'($urandom_range(42000));
        m.out_current = 9'($urandom_range(340));
        @(posedge ref_clk_i);
        meas_i <= m;
        @(posedge ref_clk_i);
        #1;
        check(32'({term1_o, term2_o, relay_o}), 32'({ef[1], ef[6], 1'b0}), "term");
        ef = expect_flags(m);
        check(32'(flags_o[1:0]), 32'(ef[1:0]), "pid tq");
        check(32'(flags_o[3:2]), 32'(ef[3:2]), "zero heat");
        check(32'(flags_o[5:4]), 32'(ef[5:4]), "overload");
        check(32'(flags_o[7:6]), 32'(ef[7:6]), "arrival");
        check(32'(flags_o[9:8]), 32'(ef[9:8]), "stage therm");
      end
    end
    cfg_write(18, 16'd250);
    repeat (4)
    begin
      @(posedge ref_clk_i);
      pulse_in_i <= 1'b1;
      @(posedge ref_clk_i);
      pulse_in_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
    end
    repeat (20) @(posedge ref_clk_i);
    #1;
    check({16'h0, pulse_count}, 32'(4 * 250 / 100), "pulse count");
    complete_run();
  end
endmodule : tb

bind dwc_compare dwc_checker chk (.ref_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .meas_i, .pulse_in_i, .pulse_out_o, .flags_o, .term1_o, .term2_o,
  .relay_o);
